// ===== pkg/tmc_consts.svh
// register map, field positions and reset values of the timer mode control
// assumes a 32-bit byte-addressed slave; included by the top module and the bench
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH

`define TMC_CTRL_OFS    8'h00
`define TMC_PERIOD_OFS  8'h04
`define TMC_COUNT_OFS   8'h08
`define TMC_STATUS_OFS  8'h0c

`define TMC_ON_BIT      0
`define TMC_MODE_LSB    8
`define TMC_MODE_MSB    12
`define TMC_ST_ACT_BIT  0
`define TMC_ST_RUN_BIT  1

`define TMC_ON_RST      1'b0
`define TMC_MODE_RST    5'h00
`define TMC_PERIOD_RST  8'hff
`define TMC_WORD_SIZE   3'h2

`endif

// ===== pkg/tmc_pkg.sv
// types shared by the timer mode control design
// assumes nothing beyond a SystemVerilog compiler
package tmc_pkg;

  typedef enum logic [1:0] {
    TMC_FREE    = 2'b00,
    TMC_ONESHOT = 2'b01,
    TMC_MONO    = 2'b10,
    TMC_RSVD    = 2'b11
  } tmc_class_t;

  typedef enum logic [1:0] {
    TMC_IDLE   = 2'b00,
    TMC_BUSY   = 2'b01,
    TMC_NONSEQ = 2'b10,
    TMC_SEQ    = 2'b11
  } tmc_htrans_t;

endpackage

// ===== src/tmc_sync_edge.sv
// two-flop synchroniser for the external reset/trigger pin with edge detect
// assumes the pin is asynchronous to hclk
`timescale 1ns/1ps
`default_nettype none

module tmc_sync_edge (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // edges come from the second and third flops, never the first
  assign level = sync_r;
  assign rise  = sync_r & ~prev_r;
  assign fall  = ~sync_r & prev_r;

endmodule

`default_nettype wire

// ===== src/tmc_counter.sv
// up counter with synchronous clear and period compare
// assumes clear and increment come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module tmc_counter #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clr,
  input  wire logic         inc,
  input  wire logic [W-1:0] period,
  output logic      [W-1:0] count_r,
  output logic              match
);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (clr) begin
      count_r <= '0;
    end else if (inc) begin
      count_r <= count_r + 1'b1;
    end
  end

  assign match = (count_r == period);

endmodule

`default_nettype wire

// ===== src/tmc_top.sv
// timer mode control: mode select, start/reset/stop logic, AHB-Lite registers
// assumes a single AHB-Lite master; ext_reset_trigger is an asynchronous pin
//
// Overview of operation
// R01: mode 00/000: counter runs while run-enable set, halts when cleared.
// R02: modes 001/010: count only with run-enable and trigger high / low.
// R03: modes 011/100/101: any/rising/falling trigger edge resets a running counter.
// R04: modes 110/111: held reset while trigger low/high, that level stops it.
// R05: one-shot 000: starts on run-enable, stops after period match.
// R06: one-shot 001/010/011: start needs run-enable plus rising/falling/any edge.
// R07: one-shot 100/101: edge starts, further same-polarity edge resets count.
// R08: one-shot 110/111: rise/fall starts, reset while trigger low/high.
// R09: monostable 001/010/011: edge starts, 000 reserved, stops after match.
// R10: class 10 110/111 level start and reset; 100, 101, class 11 reserved.
// R11: edge-start modes never start without a fresh edge after run-enable.
// R12: one-shot match: next clock clears run-enable, counter stops at zero.
// R13: monostable match: next clock stops counter at zero, run-enable kept.
// R14: counter increments each clock while active, compared with period each cycle.
//
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tmc_consts.svh"

module tmc_top
  import tmc_pkg::*;
#(
  parameter int unsigned W = 8
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  input  wire logic         ext_reset_trigger,
  output logic      [31:0]  hrdata,
  output logic              hreadyout,
  output logic              hresp,
  output logic      [W-1:0] count_value
);

  logic         on_r;
  logic         on_nxt;
  logic [4:0]   mode_r;
  logic [W-1:0] period_r;
  logic         running_r;
  logic         running_nxt;
  logic         wr_pend_r;
  logic         rd_pend_r;
  logic [7:0]   ap_addr_r;
  logic         ers;
  logic         rise;
  logic         fall;
  logic         match;

  // bus slave: writes are zero-wait, reads take one wait state
  wire ap_take = hsel & hready & (tmc_htrans_t'(htrans) == TMC_NONSEQ |
                                   tmc_htrans_t'(htrans) == TMC_SEQ);
  wire ap_ok   = (haddr[31:8] == 24'h000000) & (hsize == `TMC_WORD_SIZE);
  wire wr_ctrl = wr_pend_r & (ap_addr_r == `TMC_CTRL_OFS);
  wire wr_per  = wr_pend_r & (ap_addr_r == `TMC_PERIOD_OFS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      ap_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= ap_take & hwrite & ap_ok;
      rd_pend_r <= ap_take & ~hwrite;
      if (ap_take) begin
        ap_addr_r <= ap_ok ? haddr[7:0] : 8'hff;
      end
    end
  end

  // mode decode
  wire [2:0]  lo       = mode_r[2:0];
  tmc_class_t cls;
  assign cls = tmc_class_t'(mode_r[4:3]);

  wire is_free  = (cls == TMC_FREE);
  wire is_os    = (cls == TMC_ONESHOT);
  // R09 monostable range
  wire is_mono  = (cls == TMC_MONO) & (lo != 3'h0) & (lo <= 3'h3);
  // R10 level one-shot, rest reserved
  wire is_lvl   = (cls == TMC_MONO) & (lo[2:1] == 2'b11);
  wire trig_md  = is_os | is_mono | is_lvl;

  wire any_edge   = rise | fall;
  wire start_rise = (lo == 3'h1) | (lo == 3'h4) | (lo == 3'h6);
  // R06 edge start select
  wire edge_evt   = (lo == 3'h0) ? 1'b1 :
                    (lo == 3'h3) ? any_edge :
                    start_rise   ? rise : fall;
  // R10 level start
  wire start_evt  = is_lvl ? (lo[0] ? ~ers : ers) : edge_evt;

  // R04 level reset
  // R08 one-shot level reset
  wire lvl_reset  = (is_free | is_os | is_lvl) &
                    (((lo == 3'h6) & ~ers) | ((lo == 3'h7) & ers));
  // R03 edge reset
  wire edg_reset  = (is_free & (((lo == 3'h3) & any_edge) |
                                ((lo == 3'h4) & rise) | ((lo == 3'h5) & fall))) |
                    // R07 retrigger reset
                    (is_os & (((lo == 3'h4) & rise) | ((lo == 3'h5) & fall)));

  // R02 hardware gate
  wire free_gate  = (lo == 3'h1) ? ers : (lo == 3'h2) ? ~ers : 1'b1;
  // R01 software gate
  wire free_run   = is_free & on_r & free_gate & ~lvl_reset;
  wire active     = free_run | (trig_md & running_r & on_r & ~lvl_reset);
  wire trig_done  = trig_md & active & match;
  // R14 count and compare
  wire cnt_clr    = lvl_reset | edg_reset | (active & match);
  wire cnt_inc    = active & ~match & ~edg_reset;

  // R11 fresh edge needed
  // R05 software start
  assign running_nxt = (~trig_md | ~on_r) ? 1'b0 :
                       trig_done          ? 1'b0 :
                       start_evt          ? 1'b1 : running_r;

  // R12 one-shot clears enable; R13 monostable keeps it
  // a software write in the same cycle beats the hardware clear
  assign on_nxt = wr_ctrl ? hwdata[`TMC_ON_BIT] :
                  (trig_done & (is_os | is_lvl)) ? 1'b0 : on_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_r      <= `TMC_ON_RST;
      mode_r    <= `TMC_MODE_RST;
      period_r  <= W'(`TMC_PERIOD_RST);
      running_r <= 1'b0;
    end else begin
      on_r      <= on_nxt;
      running_r <= running_nxt;
      if (wr_ctrl) begin
        mode_r <= hwdata[`TMC_MODE_MSB:`TMC_MODE_LSB];
      end
      if (wr_per) begin
        period_r <= hwdata[W-1:0];
      end
    end
  end

  // read data sampled in the wait cycle so a preceding write is visible
  wire [31:0] rd_ctrl = {19'h0, mode_r, 7'h0, on_r};
  wire [31:0] rd_stat = {30'h0, running_r, active};
  wire [31:0] rd_mux  = (ap_addr_r == `TMC_CTRL_OFS)   ? rd_ctrl :
                        (ap_addr_r == `TMC_PERIOD_OFS) ? 32'(period_r) :
                        (ap_addr_r == `TMC_COUNT_OFS)  ? 32'(count_value) :
                        (ap_addr_r == `TMC_STATUS_OFS) ? rd_stat : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend_r) begin
      hrdata <= rd_mux;
    end
  end

  assign hreadyout = ~rd_pend_r;
  assign hresp     = 1'b0;

  tmc_sync_edge u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .pin   (ext_reset_trigger),
    .level (ers),
    .rise  (rise),
    .fall  (fall)
  );

  tmc_counter #(
    .W (W)
  ) u_cnt (
    .clk     (hclk),
    .rst_n   (hresetn),
    .clr     (cnt_clr),
    .inc     (cnt_inc),
    .period  (period_r),
    .count_r (count_value),
    .match   (match)
  );

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sw_gate_a: assert property ( // R01
    (is_free & (lo == 3'h0) & ~on_r & ~edg_reset) |=> $stable(count_value))
    else $error("software gate off but counter moved");

  hw_gate_a: assert property ( // R02
    (is_free & (lo == 3'h1) & ~ers) |=> $stable(count_value))
    else $error("high gate inactive but counter moved");

  edge_reset_a: assert property ( // R03
    (is_free & (lo == 3'h4) & rise) |=> (count_value == '0))
    else $error("rising edge did not reset free counter");

  level_hold_a: assert property ( // R04
    (is_free & (lo == 3'h6) & ~ers) [*2] |-> (count_value == '0))
    else $error("low level did not hold counter in reset");

  os_stop_a: assert property ( // R12
    (is_os & running_r & active & match & ~wr_ctrl)
      |=> (count_value == '0) & ~running_r & ~on_r)
    else $error("one-shot did not stop and clear enable");

  mono_keep_a: assert property ( // R13
    (is_mono & active & match & ~wr_ctrl)
      |=> (count_value == '0) & ~running_r & on_r)
    else $error("monostable stop wrong");

  edge_start_a: assert property ( // R11
    (is_os & (lo == 3'h1) & ~running_r & ~rise) |=> ~running_r)
    else $error("one-shot started without rising edge");

  retrig_a: assert property ( // R07
    (is_os & (lo == 3'h4) & active & rise) |=> (count_value == '0))
    else $error("same-polarity edge did not reset one-shot");

  os_lvl_reset_a: assert property ( // R08
    (is_os & (lo == 3'h7) & ers) |=> (count_value == '0))
    else $error("high level did not reset one-shot");

  rsvd_mode_a: assert property ( // R10
    ((cls == TMC_RSVD) | ((cls == TMC_MONO) & (lo == 3'h0))) |=> $stable(count_value))
    else $error("reserved mode moved the counter");

  incr_a: assert property ( // R14
    (active & ~match & ~edg_reset & ~lvl_reset)
      |=> (count_value == W'($past(count_value) + 1'b1)))
    else $error("active counter did not increment");

  idle_hold_a: assert property ( // R14
    (~active & ~lvl_reset & ~edg_reset) |=> $stable(count_value))
    else $error("idle counter moved");

  free_wrap_a: assert property ( // R14
    (free_run & match) |=> (count_value == '0))
    else $error("free counter did not wrap at period");

  low_gate_a: assert property ( // R02
    (is_free & (lo == 3'h2) & ers) |=> $stable(count_value))
    else $error("low gate inactive but counter moved");

  any_reset_a: assert property ( // R03
    (is_free & (lo == 3'h3) & (rise | fall)) |=> (count_value == '0))
    else $error("edge did not reset free counter");

  fall_reset_a: assert property ( // R03
    (is_free & (lo == 3'h5) & fall) |=> (count_value == '0))
    else $error("falling edge did not reset free counter");

  high_hold_a: assert property ( // R04
    (is_free & (lo == 3'h7) & ers) |=> (count_value == '0))
    else $error("high level did not hold counter in reset");

  sw_start_a: assert property ( // R05
    (is_os & (lo == 3'h0) & on_r & ~running_r) |=> running_r)
    else $error("one-shot did not start on enable");

  fall_start_a: assert property ( // R06
    (is_os & (lo == 3'h2) & ~running_r & ~fall) |=> ~running_r)
    else $error("one-shot started without falling edge");

  any_start_a: assert property ( // R06
    (is_os & (lo == 3'h3) & ~running_r & ~(rise | fall)) |=> ~running_r)
    else $error("one-shot started without any edge");

  mono_start_a: assert property ( // R09
    (is_mono & (lo == 3'h1) & on_r & ~running_r & rise) |=> running_r)
    else $error("monostable did not start on rising edge");

  mono_any_a: assert property ( // R09
    (is_mono & (lo == 3'h3) & ~running_r & ~(rise | fall)) |=> ~running_r)
    else $error("monostable started without an edge");

  lvl_start_a: assert property ( // R10
    (is_lvl & (lo == 3'h6) & on_r & ~running_r & ers) |=> running_r)
    else $error("level one-shot did not start on high level");

  lvl_low_a: assert property ( // R10
    (is_lvl & (lo == 3'h6) & ~ers) |=> (count_value == '0))
    else $error("low level did not reset level one-shot");

  lvl_high_a: assert property ( // R10
    (is_lvl & (lo == 3'h7) & ers) |=> (count_value == '0))
    else $error("high level did not reset level one-shot");

  off_stop_a: assert property ( // R11
    (trig_md & ~on_r) |=> ~running_r)
    else $error("triggered counter ran with enable clear");

  lvl_done_a: assert property ( // R12
    (is_lvl & active & match & ~wr_ctrl)
      |=> (count_value == '0) & ~running_r & ~on_r)
    else $error("level one-shot did not stop and clear enable");

  os_cycle_c: cover property (is_os & active & match ##1 ~on_r);
  mono_retrig_c: cover property (is_mono & active & match ##[1:20] (is_mono & active));
  free_roll_c: cover property (free_run & match ##1 (count_value == '0));
  edge_rst_c: cover property (is_free & edg_reset & active);
  lvl_done_c: cover property (is_lvl & active & match ##1 ~on_r);

endmodule

`default_nettype wire

// ===== sim/tmc_trig_src.sv
// external reset/trigger source standing in for the far side of the pin
// assumes the bench sets a level request; the pin follows after a skew
`timescale 1ns/1ps
`default_nettype none

module tmc_trig_src #(
  parameter int DLY = 3
) (
  input  wire logic lvl,
  output logic      pin
);
  // the skew keeps pin changes off hclk edges, as an unrelated source would
  assign #(DLY) pin = lvl;
endmodule

`default_nettype wire

// ===== sim/tb.sv
// bench for the timer mode control: AHB-Lite master tasks and mode scenarios
// assumes a single slave, so hready is looped back from hreadyout
`timescale 1ns/1ps
`default_nettype none
`include "tmc_consts.svh"

module tb
  import tmc_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic        lvl;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] rdat;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         pin;
  wire  [7:0]  cnt;
  int          errors;
  int          n_tests;
  logic [4:0]  md [10];
  logic [4:0]  rs [5];
  logic        s;
  logic        mono;

  tmc_top #(.W(8)) dut_u (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .hsel              (hsel),
    .haddr             (haddr),
    .htrans            (htrans),
    .hwrite            (hwrite),
    .hsize             (hsize),
    .hwdata            (hwdata),
    .hready            (hreadyout),
    .ext_reset_trigger (pin),
    .hrdata            (hrdata),
    .hreadyout         (hreadyout),
    .hresp             (hresp),
    .count_value       (cnt)
  );

  tmc_trig_src trig_u (
    .lvl (lvl),
    .pin (pin)
  );

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one single transfer; read data lands in rdat at the closing edge
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= TMC_NONSEQ;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= `TMC_WORD_SIZE;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= TMC_IDLE;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  // look only once the edge's own updates have settled
  task automatic wait_clk(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  function automatic logic [31:0] ctl(input logic [4:0] m, input logic on);
    ctl = 32'h0;
    ctl[`TMC_MODE_MSB:`TMC_MODE_LSB] = m;
    ctl[`TMC_ON_BIT] = on;
  endfunction

  task automatic pin_to(input logic l);
    @(posedge hclk);
    lvl <= l;
  endtask

  // each step either counts by one, wrapping after the period, or holds
  task automatic watch(input int n, input logic run, input logic [7:0] per);
    logic [7:0] p;
    #1;
    repeat (n) begin
      p = cnt;
      @(posedge hclk);
      #1;
      chk("count_step", {24'h0, cnt}, {24'h0, run ? ((p == per) ? 8'h00 : p + 8'h01) : p});
    end
  endtask

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // the whole sequence needs about two thousand cycles
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    final_report();
  end

  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    hwrite  = 1'b0;
    lvl     = 1'b0;
    htrans  = TMC_IDLE;
    hsize   = `TMC_WORD_SIZE;
    haddr   = 32'h0;
    hwdata  = 32'h0;
    errors  = 0;
    n_tests = 0;
    md = '{5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0f, 5'h11, 5'h12, 5'h13, 5'h16, 5'h17};
    rs = '{5'h10, 5'h14, 5'h15, 5'h18, 5'h1f};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, `TMC_CTRL_OFS, 32'h0);
    chk("ctrl_reset", rdat, 32'h0);
    ahb(1'b0, `TMC_PERIOD_OFS, 32'h0);
    chk("period_reset", rdat, 32'hff);
    ahb(1'b0, 32'h10, 32'h0);
    chk("unmapped_read", rdat, 32'h0);
    ahb(1'b1, `TMC_PERIOD_OFS, 32'h0a);
    ahb(1'b1, `TMC_CTRL_OFS, ctl(5'h00, 1'b1));
    watch(14, 1'b1, 8'h0a);
    ahb(1'b1, `TMC_CTRL_OFS, ctl(5'h00, 1'b0));
    watch(5, 1'b0, 8'h0a);
    ahb(1'b0, `TMC_COUNT_OFS, 32'h0);
    chk("count_read", rdat, 32'h6);
    ahb(1'b1, `TMC_CTRL_OFS, ctl(5'h06, 1'b1));
    wait_clk(5);
    chk("held_low", {24'h0, cnt}, 32'h0);
    pin_to(1'b1);
    repeat (5) @(posedge hclk);
    watch(5, 1'b1, 8'h0a);
    ahb(1'b1, `TMC_CTRL_OFS, ctl(5'h07, 1'b1));
    wait_clk(5);
    chk("held_high", {24'h0, cnt}, 32'h0);
    for (int g = 1; g <= 2; g++) begin
      ahb(1'b1, `TMC_CTRL_OFS, ctl(5'(g), 1'b1));
      pin_to(g == 1);
      repeat (5) @(posedge hclk);
      watch(5, 1'b1, 8'h0a);
      pin_to(g != 1);
      repeat (5) @(posedge hclk);
      watch(5, 1'b0, 8'h0a);
    end
    ahb(1'b1, `TMC_PERIOD_OFS, 32'hff);
    for (int m = 3; m <= 5; m++) begin
      s = (m == 5);
      ahb(1'b1, `TMC_CTRL_OFS, ctl(5'(m), 1'b1));
      pin_to(s);
      wait_clk(20);
      chk("pre_edge", {31'h0, cnt > 8'h08}, 32'h1);
      pin_to(!s);
      wait_clk(5);
      chk("edge_reset", {31'h0, cnt < 8'h06}, 32'h1);
    end
    ahb(1'b1, `TMC_CTRL_OFS, ctl(5'h08, 1'b1));
    wait_clk(300);
    chk("oneshot_done", {24'h0, cnt}, 32'h0);
    ahb(1'b0, `TMC_CTRL_OFS, 32'h0);
    chk("oneshot_off", rdat, ctl(5'h08, 1'b0));
    ahb(1'b1, `TMC_PERIOD_OFS, 32'h20);
    foreach (md[i]) begin
      s = (md[i][2:0] == 3'h2) || (md[i][2:0] == 3'h7);
      mono = (md[i][4:3] == 2'b10) && (md[i][2:0] < 3'h4);
      ahb(1'b1, `TMC_CTRL_OFS, ctl(md[i], 1'b0));
      pin_to(s);
      wait_clk(5);
      ahb(1'b1, `TMC_CTRL_OFS, ctl(md[i], 1'b1));
      wait_clk(20);
      chk("wait_edge", {24'h0, cnt}, 32'h0);
      pin_to(!s);
      wait_clk(8);
      chk("started", {31'h0, cnt != 8'h00}, 32'h1);
      ahb(1'b0, `TMC_STATUS_OFS, 32'h0);
      chk("status_run", rdat, 32'h3);
      if (md[i] == 5'h0c) begin
        pin_to(s);
        repeat (4) @(posedge hclk);
        pin_to(!s);
        wait_clk(5);
        chk("retrig_reset", {31'h0, cnt < 8'h06}, 32'h1);
      end
      wait_clk(60);
      chk("stopped", {24'h0, cnt}, 32'h0);
      ahb(1'b0, `TMC_CTRL_OFS, 32'h0);
      chk("on_after", rdat, ctl(md[i], mono));
      if (mono) begin
        pin_to(s);
        repeat (4) @(posedge hclk);
        pin_to(!s);
        wait_clk(8);
        chk("retrigger", {31'h0, cnt != 8'h00}, 32'h1);
        repeat (60) @(posedge hclk);
      end
    end
    foreach (rs[i]) begin
      ahb(1'b1, `TMC_CTRL_OFS, ctl(rs[i], 1'b1));
      pin_to(1'b0);
      repeat (4) @(posedge hclk);
      pin_to(1'b1);
      wait_clk(6);
      chk("reserved", {24'h0, cnt}, 32'h0);
    end
    final_report();
  end
endmodule

`default_nettype wire
